// ---- nco_tw_pkg.sv ----
// constants, types and the plain-words list for the tuning word register bank
// How it works
// RL1 - one 64-bit read/write tuning word per oscillator
// RL2 - accumulate modulo two to the sixty-four
// RL3 - written word pending until selected sync event
// RL4 - host changes words only while datapath idle; the bank still accepts word writes while datapath_enable is set
// RL5 - fast reconfiguration on: words have no effect
// RL6 - words at 320h, 328h, 330h, reset zero
// RL7 - sync bit rising write raises sync; reads back
// RL8 - little-endian bytes, byte writes touch one byte
package nco_tw_pkg;
   localparam int NUM_NCO = 3;
   localparam int WORD_W = 64;
   localparam logic [11:0] OFS_TW0 = 12'h320;
   localparam logic [11:0] OFS_TW1 = 12'h328;
   localparam logic [11:0] OFS_TW2 = 12'h330;
   localparam logic [11:0] OFS_TW_STEP = 12'h008;
   localparam logic [11:0] OFS_SYNC = 12'h304;
   localparam logic [11:0] OFS_CTRL = 12'h340;
   localparam logic [11:0] OFS_STATUS = 12'h344;
   localparam int CTRL_SRC_LSB = 0;
   localparam int CTRL_FR_BIT = 2;
   localparam int CTRL_DP_BIT = 3;
   localparam int SYNC_TRIG_BIT = 0;
   localparam logic [63:0] TW_RESET = 64'h0;
   localparam logic [31:0] CTRL_RESET = 32'h0;

   // sync source choices
   typedef enum logic [1:0] {
      src_host_bit,
      src_ext_pin,
      src_both,
      src_none
   } sync_source_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage

// ---- nco_frequency_word_regs.sv ----
// tuning word register bank with pending/active words and phase accumulators
//
// The APB slave port was chosen for this implementation.
module nco_frequency_word_regs
   import nco_tw_pkg::*;
#(
   parameter int N = NUM_NCO
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire apb_req_t apb_req,
   output apb_rsp_t apb_rsp,
   // sync inputs
   input wire logic ext_sync,
   // oscillator side
   output logic [N-1:0][WORD_W-1:0] active_word,
   output logic [N-1:0][WORD_W-1:0] phase_acc,
   output logic fast_reconfig_enable,
   output logic datapath_enable,
   output logic sync_event
);
   logic [N-1:0][WORD_W-1:0] tuning_word;
   logic [31:0] ctrl;
   logic sync_trig;
   logic ext_sync_q;
   logic host_sync_pulse;
   logic [1:0] src;
   logic access;
   logic wr;
   logic [N-1:0] pend;
   logic [31:0] next_rdata;
   logic next_err;

   assign access = apb_req.psel && apb_req.penable;
   assign wr = access && apb_req.pwrite;
   assign src = ctrl[CTRL_SRC_LSB +: 2];
   assign fast_reconfig_enable = ctrl[CTRL_FR_BIT];
   assign datapath_enable = ctrl[CTRL_DP_BIT];

   // tuning words, byte lanes little-endian within each 8-byte slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tuning_word <= '0; // RL6
      end else if (wr) begin
         for (int i = 0; i < N; i++) begin
            for (int b = 0; b < 4; b++) begin
               if (apb_req.pstrb[b] && apb_req.paddr == OFS_TW0 + 12'(i) * OFS_TW_STEP) begin
                  tuning_word[i][8*b +: 8] <= apb_req.pwdata[8*b +: 8]; // RL8
               end
               if (apb_req.pstrb[b]
                   && apb_req.paddr == OFS_TW0 + 12'(i) * OFS_TW_STEP + 12'h004) begin
                  tuning_word[i][32+8*b +: 8] <= apb_req.pwdata[8*b +: 8]; // RL8
               end
            end
         end
      end
   end

   // control and host sync bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         sync_trig <= 1'b0;
      end else if (wr && apb_req.pstrb[0]) begin
         if (apb_req.paddr == OFS_CTRL) begin
            ctrl <= {28'h0, apb_req.pwdata[3:0]};
         end
         if (apb_req.paddr == OFS_SYNC) begin
            sync_trig <= apb_req.pwdata[SYNC_TRIG_BIT]; // RL7
         end
      end
   end

   // rising write of the sync bit only, repeated ones do nothing
   assign host_sync_pulse = wr && apb_req.pstrb[0] && apb_req.paddr == OFS_SYNC
      && apb_req.pwdata[SYNC_TRIG_BIT] && !sync_trig; // RL7

   // external sync is edge sensitive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sync_q <= 1'b0;
      end else begin
         ext_sync_q <= ext_sync;
      end
   end

   always_comb begin
      case (sync_source_t'(src))
         src_host_bit: sync_event = host_sync_pulse;
         src_ext_pin: sync_event = ext_sync && !ext_sync_q;
         src_both: sync_event = host_sync_pulse || (ext_sync && !ext_sync_q);
         src_none: sync_event = 1'b0;
         default: sync_event = 1'b0;
      endcase
   end

   // pending words move to the active set only on a sync event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_word <= '0;
      end else if (sync_event && !fast_reconfig_enable) begin
         active_word <= tuning_word; // RL3 RL5
      end
   end

   // plain wrap-around add serves signed and unsigned words alike
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_acc <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (!datapath_enable) begin
               phase_acc[i] <= '0;
            end else begin
               phase_acc[i] <= phase_acc[i] + active_word[i]; // RL1 RL2
            end
         end
      end
   end

   // per-word pending flag: differs from the active copy
   always_comb begin
      for (int i = 0; i < N; i++) begin
         pend[i] = tuning_word[i] != active_word[i];
      end
   end

   // read mux, unmapped address answers slverr
   always_comb begin
      next_rdata = 32'h0;
      next_err = 1'b1;
      if (apb_req.paddr == OFS_CTRL) begin
         next_rdata = ctrl;
         next_err = 1'b0;
      end
      if (apb_req.paddr == OFS_SYNC) begin
         next_rdata = {31'h0, sync_trig};
         next_err = 1'b0;
      end
      if (apb_req.paddr == OFS_STATUS) begin
         next_rdata = 32'(pend);
         next_err = 1'b0;
      end
      for (int i = 0; i < N; i++) begin
         if (apb_req.paddr == OFS_TW0 + 12'(i) * OFS_TW_STEP) begin
            next_rdata = tuning_word[i][31:0]; // RL1
            next_err = 1'b0;
         end
         if (apb_req.paddr == OFS_TW0 + 12'(i) * OFS_TW_STEP + 12'h004) begin
            next_rdata = tuning_word[i][63:32]; // RL1
            next_err = 1'b0;
         end
      end
   end

   // zero wait state slave; one driver for the whole response
   assign apb_rsp = '{
      pready: 1'b1,
      pslverr: access && next_err,
      prdata: next_rdata
   };

   a_pending_held: assert property (@(posedge pclk) disable iff (!presetn) // RL3
      !sync_event |=> $stable(active_word))
      else $error("active word changed without sync");
   a_fast_reconfig_block: assert property (@(posedge pclk) disable iff (!presetn) // RL5
      fast_reconfig_enable |=> $stable(active_word))
      else $error("active word changed in fast reconfig");
   a_sync_transfer: assert property (@(posedge pclk) disable iff (!presetn) // RL3
      sync_event && !fast_reconfig_enable |=> active_word == $past(tuning_word))
      else $error("sync did not load pending word");
   a_accum_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RL2
      datapath_enable && $past(datapath_enable)
      |-> phase_acc[0] == $past(phase_acc[0]) + $past(active_word[0]))
      else $error("accumulator step wrong");
   a_host_sync_edge: assert property (@(posedge pclk) disable iff (!presetn) // RL7
      sync_trig && src == 2'd0 |-> !sync_event)
      else $error("sync raised while bit already set");
   a_sync_readback: assert property (@(posedge pclk) disable iff (!presetn) // RL7
      wr && apb_req.paddr == OFS_SYNC && apb_req.pstrb[0]
      |=> sync_trig == $past(apb_req.pwdata[0]))
      else $error("sync bit readback wrong");
   a_byte_write: assert property (@(posedge pclk) disable iff (!presetn) // RL8
      wr && apb_req.paddr == OFS_TW0 && apb_req.pstrb == 4'h1
      |=> tuning_word[0][63:8] == $past(tuning_word[0][63:8]))
      else $error("byte write touched other bytes");
   a_word_read: assert property (@(posedge pclk) disable iff (!presetn) // RL1 RL6
      access && !apb_req.pwrite && apb_req.paddr == OFS_TW1
      |-> apb_rsp.prdata == tuning_word[1][31:0] && !apb_rsp.pslverr)
      else $error("tuning word read wrong");

   // sync sources, write path, accumulator clear, status and unmapped space
   a_pin_level_only: assert property (@(posedge pclk) disable iff (!presetn) // RL3
      sync_source_t'(src) == src_ext_pin && ext_sync && ext_sync_q |-> !sync_event)
      else $error("held pin level raised sync");
   a_no_source: assert property (@(posedge pclk) disable iff (!presetn) // RL3
      sync_source_t'(src) == src_none |-> !sync_event)
      else $error("sync raised with no source");
   a_word_write: assert property (@(posedge pclk) disable iff (!presetn) // RL1
      wr && apb_req.paddr == OFS_TW2 && apb_req.pstrb == 4'hF
      |=> tuning_word[2][31:0] == $past(apb_req.pwdata))
      else $error("full word write lost");
   a_accum_clear: assert property (@(posedge pclk) disable iff (!presetn) // RL1
      !datapath_enable |=> phase_acc == '0)
      else $error("accumulator not cleared while idle");
   a_status_read: assert property (@(posedge pclk) disable iff (!presetn) // RL3
      access && !apb_req.pwrite && apb_req.paddr == OFS_STATUS
      |-> apb_rsp.prdata[0] == (tuning_word[0] != active_word[0]))
      else $error("pending flag read wrong");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // RL6
      access && apb_req.paddr == OFS_TW2 + OFS_TW_STEP |-> apb_rsp.pslverr)
      else $error("slot past the third word answered");

   // main scenarios
   c_sync_load: cover property (@(posedge pclk) disable iff (!presetn)
      sync_event && !fast_reconfig_enable && pend[0]);
   c_fr_blocked: cover property (@(posedge pclk) disable iff (!presetn)
      sync_event && fast_reconfig_enable);
   c_accum_run: cover property (@(posedge pclk) disable iff (!presetn)
      datapath_enable && active_word[2] != 64'h0);
   c_pin_load: cover property (@(posedge pclk) disable iff (!presetn)
      sync_source_t'(src) == src_ext_pin && sync_event);
   c_host_repeat: cover property (@(posedge pclk) disable iff (!presetn)
      wr && apb_req.paddr == OFS_SYNC && apb_req.pwdata[SYNC_TRIG_BIT] && sync_trig);
endmodule

// ---- tb_top.sv ----
// self-checking testbench for the tuning word register bank
module tb_top import nco_tw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   // external sync idles low; only the pin scenario raises it
   logic ext_sync = 1'b0;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   logic [NUM_NCO-1:0][WORD_W-1:0] aw, pa;
   logic fr, dp, sev;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic er;
   logic [63:0] v, p;

   always #5 pclk = ~pclk;

   nco_frequency_word_regs nco_frequency_word_regs_inst (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .ext_sync(ext_sync),
      .active_word(aw), .phase_acc(pa), .fast_reconfig_enable(fr), .datapath_enable(dp),
      .sync_event(sev));

   task end_of_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   // one apb transfer; held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1) @(posedge pclk);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req <= '0;
   endtask

   function automatic logic [11:0] ofs(input int n);
      return 12'(OFS_TW0 + OFS_TW_STEP * n);
   endfunction

   function automatic logic [63:0] tw(input int n);
      return 64'hFEDC_BA98_7654_3210 ^ {8{8'(n)}};
   endfunction

   task automatic wr64(input int n, input logic [63:0] x);
      apb(1'b1, ofs(n), x[31:0], 4'hF);
      apb(1'b1, ofs(n) + 12'h004, x[63:32], 4'hF);
   endtask

   task automatic rd64(input int n);
      apb(1'b0, ofs(n), 32'h0, 4'h0);
      v[31:0] = rd;
      apb(1'b0, ofs(n) + 12'h004, 32'h0, 4'h0);
      v[63:32] = rd;
   endtask

   // clear then set the host bit; active words land one edge later
   task automatic host_sync;
      apb(1'b1, OFS_SYNC, 32'h0, 4'hF);
      apb(1'b1, OFS_SYNC, 32'h1, 4'hF);
      @(posedge pclk);
   endtask

   task automatic t_reset;
      for (int n = 0; n < NUM_NCO; n++) begin
         rd64(n);
         chk(v, TW_RESET, "word after reset");
         chk(aw[n], TW_RESET, "active after reset");
      end
   endtask

   task automatic t_pending_sync;
      for (int n = 0; n < NUM_NCO; n++) wr64(n, tw(n));
      for (int n = 0; n < NUM_NCO; n++) begin
         rd64(n);
         chk(v, tw(n), "word readback");
         chk(aw[n], TW_RESET, "active moved before sync");
      end
      apb(1'b0, OFS_STATUS, 32'h0, 4'h0);
      chk(64'(rd), 64'h7, "all three words pending");
      host_sync;
      for (int n = 0; n < NUM_NCO; n++) chk(aw[n], tw(n), "active after sync");
      apb(1'b0, OFS_SYNC, 32'h0, 4'h0);
      chk(64'(rd[0]), 64'h1, "sync bit readback");
   endtask

   task automatic t_bytes;
      apb(1'b1, ofs(1) + 12'h004, 32'h00EE_0000, 4'h4);
      rd64(1);
      p = tw(1);
      chk(v, {p[63:56], 8'hEE, p[47:0]}, "byte lane write");
      apb(1'b1, ofs(0), 32'h0000_00AB, 4'h1);
      rd64(0);
      p = tw(0);
      chk(v, {p[63:8], 8'hAB}, "low byte write");
      // bit already set: writing one again must not load
      apb(1'b1, OFS_SYNC, 32'h1, 4'hF);
      @(posedge pclk);
      chk(aw[1], tw(1), "sync without re-arm");
      apb(1'b0, OFS_TW2 + OFS_TW_STEP, 32'h0, 4'h0);
      chk(64'(er), 64'h1, "unmapped error flag");
   endtask

   task automatic t_fast;
      apb(1'b1, OFS_CTRL, 32'h4, 4'hF);
      @(posedge pclk);
      chk(64'(fr), 64'h1, "fast reconfig bit");
      wr64(2, ~tw(2));
      host_sync;
      chk(aw[2], tw(2), "word took effect in fast mode");
      apb(1'b1, OFS_CTRL, 32'h0, 4'hF);
   endtask

   // a negative word must wrap the accumulator modulo 2**64
   task automatic t_accum;
      wr64(0, 64'hFFFF_FFFF_FFFF_FFFD);
      host_sync;
      apb(1'b1, OFS_CTRL, 32'h8, 4'hF);
      @(posedge pclk);
      chk(64'(dp), 64'h1, "datapath enable bit");
      repeat (3) @(posedge pclk);
      p = pa[0];
      @(posedge pclk);
      chk(pa[0], p + 64'hFFFF_FFFF_FFFF_FFFD, "accumulator step");
   endtask

   // pin source: a rising edge loads, a held level does not
   task automatic t_ext;
      apb(1'b1, OFS_CTRL, 32'h1, 4'hF);
      p = aw[1];
      wr64(1, tw(0));
      chk(aw[1], p, "active moved before pin edge");
      @(posedge pclk);
      ext_sync <= 1'b1;
      @(posedge pclk);
      chk(64'(sev), 64'h1, "pin edge event");
      @(posedge pclk);
      chk(64'(sev), 64'h0, "event lasts one cycle");
      chk(aw[1], tw(0), "active after pin edge");
      wr64(1, tw(2));
      repeat (2) @(posedge pclk);
      chk(aw[1], tw(0), "held pin level loaded again");
      ext_sync <= 1'b0;
      apb(1'b1, OFS_CTRL, 32'h3, 4'hF);
      host_sync;
      chk(aw[1], tw(0), "load with no source selected");
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_pending_sync;
      t_bytes;
      t_fast;
      t_accum;
      t_ext;
      end_of_test;
   end

   // ceiling far above the under two hundred cycles the tests need
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         end_of_test;
      end
   end
endmodule
